// File: hdl/stc_top.sv
// fast or trickle decision from voltage slope, temperature and timeout
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "stc_consts.svh"

//
// Contract
// - battery voltage is taken as codes of 2.5mV per step
// - first measurement follows one selectable interval of 21 to 168 s
// - each measurement takes a 5 ms conversion window
// - second measurement after another interval, then the pair is compared
// - without termination the two-interval two-measurement cycle repeats
// - zero-slope variant ends fast charge on equal codes
// - negative-slope variant ends fast charge on a drop of cells steps
// - hot comparator ends fast charge at once
// - cooling after a hot end never restarts fast charge
// - cold at startup withholds fast charge until it clears
// - exactly one state, fast or trickle, is held
// - timeout or slope end forces trickle whatever else holds
// - only the first clearing of startup cold starts fast charge
// - hot at startup blocks fast charge until reset
module stc_top
  import stc_pkg::*;
#(
  parameter int TICK_CYCLES = `STC_TICK_CYCLES,
  parameter int BASE_INTERVAL_TICKS = `STC_BASE_INTERVAL_TICKS,
  parameter int CONV_TICKS = `STC_CONV_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic [`STC_CODE_W-1:0] conv_code,
  input wire logic hot_above,
  input wire logic cold_below,
  input wire logic charge_timeout,
  output logic conv_start,
  output logic fast_charge,
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    stc_phase_e phase;
    logic started;
    logic fast;
    logic hot_lock;
    logic term_lock;
    logic cold_wait;
    logic conv_start;
    stc_code_t code_a;
    stc_code_t code_b;
    logic neg;
    logic [1:0] sel;
    logic [3:0] cells_m1;
    logic [`STC_IRQ_W-1:0] irq_stat;
    logic [`STC_IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] rd_data;
  } stc_state_s;

  stc_state_s r;
  stc_state_s n;
  logic [`STC_IRQ_W-1:0] ev;
  logic [`STC_IRQ_W-1:0] clr;
  logic tmr_restart;
  logic tmr_done;
  logic [`STC_TIMER_W-1:0] tmr_target;

  // ==========================================================
  // timer target follows the current phase
  function automatic logic [`STC_TIMER_W-1:0] stc_target(
    input stc_phase_e ph,
    input logic [1:0] sel
  );
    logic [`STC_TIMER_W-1:0] base;
    base = `STC_TIMER_W'(BASE_INTERVAL_TICKS);
    if (ph == STC_CONV_A || ph == STC_CONV_B) begin
      return `STC_TIMER_W'(CONV_TICKS);
    end
    // select doubles the base: 21, 42, 84 or 168 s
    return base << sel;
  endfunction : stc_target

  assign tmr_target = stc_target(r.phase, r.sel);

  // the count only runs while charging fast and restarts on each phase entry
  assign tmr_restart = (n.phase != r.phase) || !r.fast;

  stc_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(tmr_restart),
    .target(tmr_target),
    .done(tmr_done)
  );

  // ==========================================================
  // register decode, shared by the write and the read path
  typedef enum logic [2:0] {
    STC_REG_NONE = 3'h0,
    STC_REG_CTRL = 3'h1,
    STC_REG_STATUS = 3'h2,
    STC_REG_CODES = 3'h3,
    STC_REG_IRQ_STAT = 3'h4,
    STC_REG_IRQ_MASK = 3'h5
  } stc_reg_e;

  function automatic stc_reg_e stc_decode(input logic [7:0] a);
    unique case (a)
      `STC_OFS_CTRL: begin
        return STC_REG_CTRL;
      end
      `STC_OFS_STATUS: begin
        return STC_REG_STATUS;
      end
      `STC_OFS_CODES: begin
        return STC_REG_CODES;
      end
      `STC_OFS_IRQ_STAT: begin
        return STC_REG_IRQ_STAT;
      end
      `STC_OFS_IRQ_MASK: begin
        return STC_REG_IRQ_MASK;
      end
      default: begin
        return STC_REG_NONE;
      end
    endcase
  endfunction : stc_decode

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    n.conv_start = 1'b0;
    n.rd_data = '0;

    // startup sample of the temperature comparators
    if (!r.started) begin
      n.started = 1'b1;
      if (hot_above) begin
        n.hot_lock = 1'b1;
      end else if (cold_below) begin
        n.cold_wait = 1'b1;
      end else begin
        n.fast = 1'b1;
      end
    end else if (r.cold_wait && !cold_below) begin
      // cold_wait never sets again, so later edges do nothing
      n.cold_wait = 1'b0;
      if (!r.hot_lock && !r.term_lock && !hot_above) begin
        n.fast = 1'b1;
      end
    end

    // slope measurement cycle
    unique case (r.phase)
      STC_WAIT_A: begin
        if (r.fast && tmr_done) begin
          n.phase = STC_CONV_A;
          n.conv_start = 1'b1;
        end
      end
      STC_CONV_A: begin
        if (tmr_done) begin
          n.code_a = conv_code;
          n.phase = STC_WAIT_B;
          ev[`STC_IRQ_MEAS] = 1'b1;
        end
      end
      STC_WAIT_B: begin
        if (tmr_done) begin
          n.phase = STC_CONV_B;
          n.conv_start = 1'b1;
        end
      end
      STC_CONV_B: begin
        if (tmr_done) begin
          n.code_b = conv_code;
          n.phase = STC_WAIT_A;
          ev[`STC_IRQ_MEAS] = 1'b1;
          if (stc_slope_end(r.neg, r.code_a, conv_code, r.cells_m1)) begin
            n.term_lock = 1'b1;
            n.fast = 1'b0;
            ev[`STC_IRQ_SLOPE] = 1'b1;
          end
        end
      end
      STC_HALT: begin
        n.phase = STC_HALT;
      end
      default: begin
        n.phase = STC_HALT;
      end
    endcase

    // terminations override any start in the same cycle
    if (r.started && hot_above) begin
      n.hot_lock = 1'b1;
      n.fast = 1'b0;
      if (r.fast) begin
        ev[`STC_IRQ_HOT] = 1'b1;
      end
    end
    if (charge_timeout) begin
      n.term_lock = 1'b1;
      n.fast = 1'b0;
      if (r.fast) begin
        ev[`STC_IRQ_TIMEOUT] = 1'b1;
      end
    end

    // once trickle is reached by any cause the slope cycle stops
    if (r.fast && !n.fast) begin
      n.phase = STC_HALT;
    end
    // taken from the transition, so a start cancelled in the same cycle reports nothing
    if (!r.fast && n.fast) begin
      ev[`STC_IRQ_FAST] = 1'b1;
    end

    // register writes
    if (wr_en) begin
      unique case (stc_decode(addr))
        STC_REG_CTRL: begin
          n.neg = wr_data[`STC_CTRL_NEG_BIT];
          n.sel = wr_data[`STC_CTRL_SEL_HI:`STC_CTRL_SEL_LO];
          n.cells_m1 = wr_data[`STC_CTRL_CELLS_HI:`STC_CTRL_CELLS_LO];
        end
        STC_REG_IRQ_STAT: begin
          clr = wr_data[`STC_IRQ_W-1:0];
        end
        STC_REG_IRQ_MASK: begin
          n.irq_mask = wr_data[`STC_IRQ_W-1:0];
        end
        default: begin
          n.irq_mask = r.irq_mask;
        end
      endcase
    end

    // a new event in the clearing cycle survives
    n.irq_stat = (r.irq_stat & ~clr) | ev;
    n.irq = |(n.irq_stat & n.irq_mask);

    // register reads, answered one cycle later
    if (rd_en) begin
      unique case (stc_decode(addr))
        STC_REG_CTRL: begin
          n.rd_data[`STC_CTRL_NEG_BIT] = r.neg;
          n.rd_data[`STC_CTRL_SEL_HI:`STC_CTRL_SEL_LO] = r.sel;
          n.rd_data[`STC_CTRL_CELLS_HI:`STC_CTRL_CELLS_LO] = r.cells_m1;
        end
        STC_REG_STATUS: begin
          n.rd_data[`STC_ST_FAST_BIT] = r.fast;
          n.rd_data[`STC_ST_HOT_BIT] = r.hot_lock;
          n.rd_data[`STC_ST_TERM_BIT] = r.term_lock;
          n.rd_data[`STC_ST_COLD_BIT] = r.cold_wait;
          n.rd_data[`STC_ST_PHASE_HI:`STC_ST_PHASE_LO] = r.phase;
        end
        STC_REG_CODES: begin
          n.rd_data[`STC_CODE_W-1:0] = r.code_a;
          n.rd_data[`STC_CODES_B_LO +: `STC_CODE_W] = r.code_b;
        end
        STC_REG_IRQ_STAT: begin
          n.rd_data[`STC_IRQ_W-1:0] = r.irq_stat;
        end
        STC_REG_IRQ_MASK: begin
          n.rd_data[`STC_IRQ_W-1:0] = r.irq_mask;
        end
        default: begin
          n.rd_data = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.phase <= STC_WAIT_A;
      r.neg <= `STC_NEG_RST;
      r.sel <= `STC_SEL_RST;
      r.cells_m1 <= `STC_CELLS_M1_RST;
      r.irq_mask <= `STC_IRQ_MASK_RST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign rd_data = r.rd_data;
  assign conv_start = r.conv_start;
  assign fast_charge = r.fast;
  assign irq = r.irq;

endmodule : stc_top

// File: hdl/stc_consts.svh
// constants of the slope and temperature charge terminator
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// ==========================================================
// clock and time base
`define STC_CLK_PERIOD_NS 4
`define STC_TICK_TIME_NS 1000000
`define STC_TICK_CYCLES ((`STC_TICK_TIME_NS + `STC_CLK_PERIOD_NS - 1) / `STC_CLK_PERIOD_NS)
`define STC_TICK_MS 1
`define STC_BASE_INTERVAL_MS 21000
`define STC_BASE_INTERVAL_TICKS (`STC_BASE_INTERVAL_MS / `STC_TICK_MS)
`define STC_CONV_TIME_MS 5
`define STC_CONV_TICKS ((`STC_CONV_TIME_MS + `STC_TICK_MS - 1) / `STC_TICK_MS)
`define STC_TIMER_W 20

// ==========================================================
// conversion codes
`define STC_CODE_W 12
`define STC_CODE_LSB_UV 2500

// ==========================================================
// register offsets
`define STC_OFS_CTRL 8'h00
`define STC_OFS_STATUS 8'h04
`define STC_OFS_CODES 8'h08
`define STC_OFS_IRQ_STAT 8'h0C
`define STC_OFS_IRQ_MASK 8'h10

// ==========================================================
// control fields and reset values
`define STC_CTRL_NEG_BIT 0
`define STC_CTRL_SEL_LO 1
`define STC_CTRL_SEL_HI 2
`define STC_CTRL_CELLS_LO 4
`define STC_CTRL_CELLS_HI 7
`define STC_NEG_RST 1'h0
`define STC_SEL_RST 2'h0
`define STC_CELLS_M1_RST 4'h0

// ==========================================================
// status fields
`define STC_ST_FAST_BIT 0
`define STC_ST_HOT_BIT 1
`define STC_ST_TERM_BIT 2
`define STC_ST_COLD_BIT 3
`define STC_ST_PHASE_LO 4
`define STC_ST_PHASE_HI 6
`define STC_CODES_B_LO 16

// ==========================================================
// interrupt bits
`define STC_IRQ_W 5
`define STC_IRQ_SLOPE 0
`define STC_IRQ_HOT 1
`define STC_IRQ_TIMEOUT 2
`define STC_IRQ_FAST 3
`define STC_IRQ_MEAS 4
`define STC_IRQ_MASK_RST 5'h00

`endif

// File: hdl/stc_pkg.sv
// types and shared arithmetic of the charge terminator
`include "stc_consts.svh"

package stc_pkg;

  // ==========================================================
  // measurement phases, gray coded along the cycle
  typedef enum logic [2:0] {
    STC_WAIT_A = 3'h0,
    STC_CONV_A = 3'h1,
    STC_WAIT_B = 3'h3,
    STC_CONV_B = 3'h2,
    STC_HALT = 3'h6
  } stc_phase_e;

  typedef logic [`STC_CODE_W-1:0] stc_code_t;

  // ==========================================================
  // true when a pair of codes ends fast charge
  function automatic logic stc_slope_end(
    input logic neg,
    input stc_code_t first,
    input stc_code_t second,
    input logic [3:0] cells_m1
  );
    logic [`STC_CODE_W:0] limit;
    limit = {1'b0, second} + {{(`STC_CODE_W-3){1'b0}}, cells_m1} + 13'h0001;
    if (neg) begin
      // one code step per cell, so a drop of at least cells steps
      return {1'b0, first} >= limit;
    end
    return first == second;
  endfunction : stc_slope_end

endpackage : stc_pkg

// File: hdl/stc_timer.sv
// tick prescaler and tick counter used for intervals and conversion windows
`timescale 1ns/1ns
`include "stc_consts.svh"

module stc_timer
  import stc_pkg::*;
#(
  parameter int TICK_CYCLES = `STC_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [`STC_TIMER_W-1:0] target,
  output logic done
);

  typedef struct packed {
    logic [31:0] pre;
    logic [`STC_TIMER_W-1:0] cnt;
    logic done;
  } stc_tmr_s;

  stc_tmr_s r;
  stc_tmr_s n;

  always_comb begin
    n = r;
    if (restart) begin
      n = '0;
    end else if (!r.done) begin
      if (r.pre == 32'(TICK_CYCLES - 1)) begin
        n.pre = '0;
        n.cnt = r.cnt + 20'h00001;
        // sticks until the owner restarts, so no expiry is missed
        if (n.cnt >= target) begin
          n.done = 1'b1;
        end
      end else begin
        n.pre = r.pre + 32'h00000001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done = r.done;

endmodule : stc_timer

// File: dv/stc_conv_model.sv
// converter model: hands out one battery code per conversion window
`timescale 1ns/1ns
module stc_conv_model
  import stc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire stc_code_t [3:0] codes,
  output stc_code_t conv_code
);
  logic [1:0] idx;
  logic [3:0] age;
  // ==========================================
  // converter
  // code steps are 2.5 mV; the value is held well past the window end
  // once released the line toggles, so a late sample cannot pass by luck
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 2'h0;
      age <= 4'hF;
      conv_code <= 12'hAAA;
    end else if (conv_start) begin
      conv_code <= codes[idx];
      idx <= idx + 2'h1;
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end else begin
      conv_code <= ~conv_code;
    end
  end
endmodule : stc_conv_model

// File: dv/stc_top_asserts.sv
// concurrent checks on the ports of the charge terminator
`timescale 1ns/1ns
`include "stc_consts.svh"
module stc_top_asserts
  import stc_pkg::*;
#(
  parameter int TICK_CYCLES = `STC_TICK_CYCLES,
  parameter int BASE_INTERVAL_TICKS = `STC_BASE_INTERVAL_TICKS,
  parameter int CONV_TICKS = `STC_CONV_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic [`STC_CODE_W-1:0] conv_code,
  input wire logic hot_above,
  input wire logic cold_below,
  input wire logic charge_timeout,
  input wire logic conv_start,
  input wire logic fast_charge,
  input wire logic irq
);
  logic was_fast;
  logic ended;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // helper: remembers that fast charge has ended since reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      was_fast <= 1'b0;
      ended <= 1'b0;
    end else begin
      was_fast <= fast_charge;
      ended <= ended | (was_fast & ~fast_charge);
    end
  end
  // ==========================================
  // properties
  a_hot_ends_fast: assert property (hot_above |=> !fast_charge)
    else $error("fast kept while hot");
  a_timeout_ends: assert property (charge_timeout |=> !fast_charge)
    else $error("fast kept after timeout");
  a_no_reentry: assert property (ended |-> !fast_charge)
    else $error("fast charge resumed");
  a_cold_holds: assert property (cold_below && !fast_charge |=> !fast_charge)
    else $error("fast started while cold");
  a_start_clean: assert property ($rose(fast_charge) |->
    !$past(hot_above) && !$past(cold_below) && !$past(charge_timeout))
    else $error("fast started on a bad condition");
  a_conv_window: assert property (conv_start |=> !conv_start [*8])
    else $error("conversion restarted in window");
  a_rd_quiet: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside answer cycle");
  a_mask_off: assert property (wr_en && addr == 8'h10 && wr_data[4:0] == 5'h00 |=> !irq)
    else $error("irq with all masked");
  cover property (conv_start);
  cover property ($fell(fast_charge));
  cover property ($rose(irq));
endmodule : stc_top_asserts

bind stc_top stc_top_asserts #(
  .TICK_CYCLES(TICK_CYCLES),
  .BASE_INTERVAL_TICKS(BASE_INTERVAL_TICKS),
  .CONV_TICKS(CONV_TICKS)
) i_asserts (.*);

// File: dv/stc_top_tb_top.sv
// self-checking bench of the charge terminator with a converter model
`timescale 1ns/1ns
module stc_top_tb_top
  import stc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hot_above = 1'b0;
  logic cold_below = 1'b0;
  logic charge_timeout = 1'b0;
  logic [31:0] rd_data;
  logic [31:0] d;
  stc_code_t conv_code;
  stc_code_t [3:0] codes = '0;
  logic conv_start;
  logic fast_charge;
  logic irq;
  int bad_count = 0;
  int check_count = 0;
  int n;
  always #2 sys_clk = ~sys_clk;
  // short counts: 4 cycles a tick, 12 cycles a base interval, 8 cycles a window
  stc_top #(.TICK_CYCLES(4), .BASE_INTERVAL_TICKS(3), .CONV_TICKS(2)) i_dut (.*);
  stc_conv_model i_conv (.*);
  // ==========================================
  // bus and helper tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    cyc(2);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    cyc(1);
    d = rd_data;
  endtask : rd
  task automatic until_conv(input int lim);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (conv_start !== 1'b1 && n < lim);
  endtask : until_conv
  task automatic do_reset(input logic hot, input logic cold);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    hot_above <= hot;
    cold_below <= cold;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset
  // ==========================================
  // scenarios
  task automatic t_zero;
    codes <= {12'h064, 12'h064, 12'h065, 12'h064};
    do_reset(1'b0, 1'b0);
    until_conv(100);
    chk(n >= 12 && n <= 17, 1'b1);
    until_conv(100);
    chk(n >= 20 && n <= 24, 1'b1);
    cyc(12);
    chk(fast_charge, 1'b1);
    until_conv(100);
    until_conv(100);
    cyc(12);
    chk(fast_charge, 1'b0);
    rd(8'h08);
    chk(d, 32'h0064_0064);
    wr(8'h04, 32'h0);
    rd(8'h04);
    chk(d, 32'h64);
    rd(8'h00);
    chk(d, 32'h0);
    rd(8'h20);
    chk(d, 32'h0);
    rd(8'h0C);
    chk(d, 32'h19);
    wr(8'h10, 32'h1);
    chk(irq, 1'b1);
    wr(8'h0C, 32'h1F);
    chk(irq, 1'b0);
    $display("zero slope done");
  endtask : t_zero
  task automatic t_neg;
    codes <= {12'h0C5, 12'h0C8, 12'h0C6, 12'h0C8};
    do_reset(1'b0, 1'b0);
    wr(8'h00, 32'h27);
    until_conv(200);
    until_conv(200);
    chk(n >= 104 && n <= 108, 1'b1);
    until_conv(200);
    chk(n >= 104 && n <= 108, 1'b1);
    chk(fast_charge, 1'b1);
    until_conv(200);
    cyc(12);
    chk(fast_charge, 1'b0);
    rd(8'h08);
    chk(d, 32'h00C5_00C8);
    $display("negative slope done");
  endtask : t_neg
  task automatic t_hot;
    do_reset(1'b0, 1'b0);
    cyc(2);
    chk(fast_charge, 1'b1);
    @(posedge sys_clk);
    hot_above <= 1'b1;
    cyc(2);
    chk(fast_charge, 1'b0);
    @(posedge sys_clk);
    hot_above <= 1'b0;
    cyc(30);
    chk(fast_charge, 1'b0);
    rd(8'h0C);
    chk(d, 32'h0A);
    wr(8'h10, 32'h2);
    chk(irq, 1'b1);
    wr(8'h10, 32'h0);
    chk(irq, 1'b0);
    $display("hot end done");
  endtask : t_hot
  task automatic t_cold;
    do_reset(1'b0, 1'b1);
    cyc(10);
    chk(fast_charge, 1'b0);
    @(posedge sys_clk);
    cold_below <= 1'b0;
    cyc(3);
    chk(fast_charge, 1'b1);
    @(posedge sys_clk);
    cold_below <= 1'b1;
    @(posedge sys_clk);
    cold_below <= 1'b0;
    cyc(2);
    chk(fast_charge, 1'b1);
    @(posedge sys_clk);
    charge_timeout <= 1'b1;
    @(posedge sys_clk);
    charge_timeout <= 1'b0;
    cyc(1);
    chk(fast_charge, 1'b0);
    @(posedge sys_clk);
    cold_below <= 1'b1;
    @(posedge sys_clk);
    cold_below <= 1'b0;
    cyc(2);
    chk(fast_charge, 1'b0);
    rd(8'h0C);
    chk(d & 32'h6, 32'h4);
    do_reset(1'b1, 1'b0);
    cyc(4);
    @(posedge sys_clk);
    hot_above <= 1'b0;
    cyc(20);
    chk(fast_charge, 1'b0);
    $display("cold and hot start done");
  endtask : t_cold
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    t_zero;
    t_neg;
    t_hot;
    t_cold;
    wrap_up;
  end
  // the tests need about 700 cycles; 5000 leaves ample margin
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end
endmodule : stc_top_tb_top
